// >>> core/dsda_delay.sv
// sync delay counter: releases the second sync a programmed count later
`timescale 1ns/1ps
module dsda_delay #(
	parameter int DW = 8
) (
	// clock and reset
	input  wire logic          clock,
	input  wire logic          rst_b,
	// control
	input  wire logic          start,
	input  wire logic [DW-1:0] delay,
	// result
	output      logic          fire
);
	typedef enum logic {DSDA_IDLE, DSDA_COUNT} dsda_dstate_t;
	dsda_dstate_t  st_reg, st_next;
	logic [DW-1:0] cnt_reg, cnt_next;
	logic          fire_reg, fire_next;

	assign fire = fire_reg;

	always_comb begin
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		fire_next = 1'b0;
		unique case (st_reg)
			DSDA_IDLE: begin
				if (start && delay == '0) begin
					fire_next = 1'b1;
				end else if (start) begin
					st_next  = DSDA_COUNT;
					cnt_next = DW'(1);
				end
			end
			DSDA_COUNT: begin
				if (cnt_reg == delay) begin
					fire_next = 1'b1;
					st_next   = DSDA_IDLE;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_reg   <= DSDA_IDLE;
			cnt_reg  <= '0;
			fire_reg <= 1'b0;
		end else begin
			st_reg   <= st_next;
			cnt_reg  <= cnt_next;
			fire_reg <= fire_next;
		end
	end
endmodule : dsda_delay

// >>> core/dsda_fifo.sv
// parameterised valid/ready fifo for the aligned sample stream
`timescale 1ns/1ps
module dsda_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_b,
	// fill side
	input  wire logic             in_valid,
	output      logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output      logic             out_valid,
	input  wire logic             out_ready,
	output      logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
	logic             push, pop;

	assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
	assign out_valid = wr_reg != rd_reg;
	assign out_data  = mem[rd_reg[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_reg <= '0;
			rd_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	always_ff @(posedge clock) begin
		if (push)
			mem[wr_reg[AW-1:0]] <= in_data;
	end
endmodule : dsda_fifo

// >>> core/dsda_pkg.sv
// shared constants and types for the sync delay alignment block
package dsda_pkg;
	localparam int                NUM_CH        = 4;
	localparam int                DELAY_W       = 8;
	localparam int                DELAY_MAX     = 256;
	localparam logic [DELAY_W-1:0] DELAY_RESET  = 8'h05;
	localparam int                HOLD_MAX      = 16;
	localparam int                DATA_W        = 16;
	localparam int                FIFO_DEPTH    = 16;
	localparam int                FINE_W        = 4;
	localparam int                CLK_HZ        = 25_000_000;

	typedef struct packed {
		logic [DATA_W-1:0] i_smp;
		logic [DATA_W-1:0] q_smp;
	} dsda_iq_t;

	typedef struct packed {
		logic [DELAY_W-1:0] delay;
		logic               neg_pol;
	} dsda_chcfg_t;
endpackage : dsda_pkg

// >>> core/dsda_top.sv
// top: per-channel sync delay, channel 1/2 recapture and channel 3/4 fine delay
`timescale 1ns/1ps
module dsda_top #(
	parameter int DATA_W     = dsda_pkg::DATA_W,
	parameter int FIFO_DEPTH = dsda_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                        clock,
	input  wire logic                        rst_b,
	// per-channel configuration
	input  wire dsda_pkg::dsda_chcfg_t [3:0] ch_cfg,
	input  wire logic [3:0]                  sync_req,
	input  wire logic [dsda_pkg::FINE_W-1:0] fine_delay_34,
	// sync outputs toward the channel sync inputs
	output      logic [3:0]                  ddc_channel_sync_input,
	output      logic [3:0]                  duc_channel_sync_input,
	// divided clocks and data from the down-converter, channels 1/2
	input  wire logic [1:0]                  ddc_div_clk,
	input  wire dsda_pkg::dsda_iq_t [1:0]    ddc_data_12,
	// channel 3/4 data passing toward the up-converter
	input  wire dsda_pkg::dsda_iq_t [1:0]    ddc_data_34,
	// aligned stream toward the up-converter
	output      logic [1:0]                  duc_valid,
	input  wire logic [1:0]                  duc_ready,
	output      dsda_pkg::dsda_iq_t [1:0]    duc_data_12,
	output      dsda_pkg::dsda_iq_t [1:0]    duc_data_34,
	// status
	output      logic [3:0]                  sync_busy,
	output      logic [1:0]                  fifo_overrun
);
	localparam int W = 2 * DATA_W;
	if (DATA_W != dsda_pkg::DATA_W) begin : g_bad_width
		$error("data width must match the package sample type");
	end
	if ((1 << dsda_pkg::DELAY_W) != dsda_pkg::DELAY_MAX) begin : g_bad_delay
		$error("delay width cannot reach the full delay range");
	end

	logic [3:0] fire;
	logic [3:0] ddc_sync_reg, ddc_sync_next;
	logic [3:0] duc_sync_reg, duc_sync_next;
	logic [3:0] busy_reg, busy_next;

	// one delay counter per channel, each with its own setting
	genvar g;
	generate
		for (g = 0; g < dsda_pkg::NUM_CH; g++) begin : g_dly
			dsda_delay #(.DW(dsda_pkg::DELAY_W)) u_dly (
				.clock (clock),
				.rst_b (rst_b),
				.start (sync_req[g] && !busy_reg[g]),
				.delay (ch_cfg[g].delay),
				.fire  (fire[g])
			);
		end
	endgenerate

	// sync pulses; a new request is ignored while a delay is running
	always_comb begin
		ddc_sync_next = sync_req & ~busy_reg;
		duc_sync_next = fire;
		busy_next     = (busy_reg | ddc_sync_next) & ~fire;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ddc_sync_reg <= '0;
			duc_sync_reg <= '0;
			busy_reg     <= '0;
		end else begin
			ddc_sync_reg <= ddc_sync_next;
			duc_sync_reg <= duc_sync_next;
			busy_reg     <= busy_next;
		end
	end

	assign ddc_channel_sync_input = ddc_sync_reg;
	assign duc_channel_sync_input = duc_sync_reg;
	assign sync_busy              = busy_reg;

	// channels 1/2: divided clock is sampled on the fast clock, so only
	// whole divided cycles (plus the polarity half step) can be chosen
	logic [1:0] div_d_reg, div_d_next;
	logic [1:0] cap_stb;
	logic [1:0] ovr_reg, ovr_next;
	logic [1:0] f_in_ready;
	logic [1:0] f_has;
	dsda_pkg::dsda_iq_t [1:0] f_out;

	always_comb begin
		div_d_next = ddc_div_clk;
		for (int c = 0; c < 2; c++) begin
			// rising edge for positive polarity, falling for negative
			cap_stb[c] = ch_cfg[c].neg_pol ?
				(div_d_reg[c] && !ddc_div_clk[c]) :
				(!div_d_reg[c] && ddc_div_clk[c]);
		end
		ovr_next = ovr_reg | (cap_stb & ~f_in_ready);
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			div_d_reg <= '0;
			ovr_reg   <= '0;
		end else begin
			div_d_reg <= div_d_next;
			ovr_reg   <= ovr_next;
		end
	end

	assign fifo_overrun = ovr_reg;

	generate
		for (g = 0; g < 2; g++) begin : g_fifo
			dsda_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_fifo (
				.clock     (clock),
				.rst_b     (rst_b),
				.in_valid  (cap_stb[g]),
				.in_ready  (f_in_ready[g]),
				.in_data   (ddc_data_12[g]),
				.out_valid (f_has[g]),
				.out_ready (duc_ready[g] || !duc_valid[g]),
				.out_data  (f_out[g])
			);
		end
	endgenerate

	// registered output stage keeps ports on flip-flops
	logic [1:0]               ov_reg, ov_next;
	dsda_pkg::dsda_iq_t [1:0] od_reg, od_next;

	always_comb begin
		ov_next = ov_reg;
		od_next = od_reg;
		for (int c = 0; c < 2; c++) begin
			if (duc_ready[c] || !ov_reg[c]) begin
				ov_next[c] = f_has[c];
				od_next[c] = f_out[c];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ov_reg <= '0;
			od_reg <= '0;
		end else begin
			ov_reg <= ov_next;
			od_reg <= od_next;
		end
	end

	assign duc_valid   = ov_reg;
	assign duc_data_12 = od_reg;

	// channels 3/4: fast-clock delay line, one cycle per step
	localparam int FD = 1 << dsda_pkg::FINE_W;
	dsda_pkg::dsda_iq_t [1:0] line_reg [FD];
	dsda_pkg::dsda_iq_t [1:0] line_next [FD];
	dsda_pkg::dsda_iq_t [1:0] o34_reg, o34_next;

	always_comb begin
		line_next[0] = ddc_data_34;
		for (int k = 1; k < FD; k++)
			line_next[k] = line_reg[k-1];
		o34_next = line_reg[fine_delay_34];
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			for (int k = 0; k < FD; k++)
				line_reg[k] <= '0;
			o34_reg <= '0;
		end else begin
			line_reg <= line_next;
			o34_reg  <= o34_next;
		end
	end

	assign duc_data_34 = o34_reg;
endmodule : dsda_top

// >>> tb/dsda_conv_model.sv
// converter side model: divided clock, channel data, downstream ready
`timescale 1ns/1ps
module dsda_conv_model (
	// clock and reset
	input  wire logic                     clock,
	input  wire logic                     rst_b,
	// sync from the block and stall from the bench
	input  wire logic                     sync_in,
	input  wire logic                     stall,
	// toward the block
	output      logic [1:0]               div_clk,
	output      dsda_pkg::dsda_iq_t [1:0] data_12,
	output      dsda_pkg::dsda_iq_t [1:0] data_34,
	output      logic [1:0]               ready
);
	logic [1:0]  cnt_reg;
	logic [15:0] smp_reg;
	logic [15:0] cyc_reg;
	always_ff @(posedge clock) begin
		cnt_reg <= (!rst_b || sync_in) ? 2'h0 : cnt_reg + 2'h1;
		if (!rst_b) smp_reg <= 16'h0000;
		else if (cnt_reg == 2'h3) smp_reg <= smp_reg + 16'h0001;
		cyc_reg <= rst_b ? cyc_reg + 16'h0001 : 16'h0000;
	end
	// divide by four: each sample held four clocks unless a sync restarts the count, under the limit
	assign div_clk = {2{cnt_reg[1]}};
	assign data_12 = {2{smp_reg, ~smp_reg}};
	// fast path changes every clock so any delay error shows
	assign data_34 = {2{cyc_reg, ~cyc_reg}};
	assign ready   = {2{~stall}};
endmodule : dsda_conv_model

// >>> tb/dsda_top_asserts.sv
// concurrent checks on the sync delay alignment top ports
`timescale 1ns/1ps
module dsda_top_asserts #(
	parameter int DATA_W     = 16,
	parameter int FIFO_DEPTH = 16
) (
	// clock, reset and control
	input wire logic                        clock,
	input wire logic                        rst_b,
	input wire dsda_pkg::dsda_chcfg_t [3:0] ch_cfg,
	input wire logic [3:0]                  sync_req,
	// observed results
	input wire logic [3:0]                  ddc_channel_sync_input,
	input wire logic [3:0]                  duc_channel_sync_input,
	input wire logic [3:0]                  sync_busy,
	input wire logic [1:0]                  ddc_div_clk,
	input wire logic [1:0]                  duc_valid,
	input wire logic [1:0]                  duc_ready,
	input wire dsda_pkg::dsda_iq_t [1:0]    duc_data_12,
	input wire logic [1:0]                  fifo_overrun
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	property p_take;
		sync_req[0] && !sync_busy[0] |=> ddc_channel_sync_input[0];
	endproperty
	a_take: assert property (p_take) else $error("sync not issued");
	property p_pulse;
		ddc_channel_sync_input[0] |=> !ddc_channel_sync_input[0];
	endproperty
	a_pulse: assert property (p_pulse) else $error("sync too long");
	property p_gap;
		ddc_channel_sync_input[0] |-> ##[1:257] duc_channel_sync_input[0];
	endproperty
	a_gap: assert property (p_gap) else $error("late second sync");
	property p_busy;
		ddc_channel_sync_input[0] |-> sync_busy[0];
	endproperty
	a_busy: assert property (p_busy) else $error("count idle");
	property p_sticky;
		fifo_overrun[0] |=> fifo_overrun[0];
	endproperty
	a_sticky: assert property (p_sticky) else $error("overrun lost");
	property p_hold;
		duc_valid[0] && !duc_ready[0] |=>
			duc_valid[0] && $stable(duc_data_12[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("data not held");
	property p_pos;
		$rose(ddc_div_clk[0]) && !ch_cfg[0].neg_pol |-> ##[1:4] duc_valid[0];
	endproperty
	a_pos: assert property (p_pos) else $error("rise not captured");
	property p_neg;
		$fell(ddc_div_clk[0]) && ch_cfg[0].neg_pol |-> ##[1:4] duc_valid[0];
	endproperty
	a_neg: assert property (p_neg) else $error("fall not captured");
endmodule : dsda_top_asserts
bind dsda_top dsda_top_asserts #(.DATA_W(DATA_W), .FIFO_DEPTH(FIFO_DEPTH))
	chk_u (.clock, .rst_b, .ch_cfg, .sync_req, .ddc_channel_sync_input,
	.duc_channel_sync_input, .sync_busy, .ddc_div_clk, .duc_valid,
	.duc_ready, .duc_data_12, .fifo_overrun);

// >>> tb/dsda_top_tb.sv
// self-checking bench for the sync delay alignment top
`timescale 1ns/1ps
module dsda_top_tb;
	logic                        clock, rst_b, stall;
	dsda_pkg::dsda_chcfg_t [3:0] ch_cfg;
	logic [3:0]                  sync_req, ddc_sy, duc_sy, busy, fine;
	logic [1:0]                  div_clk, vld, rdy, ovr;
	dsda_pkg::dsda_iq_t [1:0]    d12, d34, q12, q34;
	dsda_pkg::dsda_iq_t          x;
	int                          cyc, k, n, miscompares, total_checks;
	int                          ph [2];
	logic [7:0]                  dl [4] = '{8'h00, 8'h01, 8'h05, 8'hff};
	logic [3:0]                  fl [3] = '{4'h3, 4'hf, 4'h0};
	dsda_top dut_u (
		.clock, .rst_b, .ch_cfg, .sync_req, .fine_delay_34(fine),
		.ddc_channel_sync_input(ddc_sy), .duc_channel_sync_input(duc_sy),
		.ddc_div_clk(div_clk), .ddc_data_12(d12), .ddc_data_34(d34),
		.duc_valid(vld), .duc_ready(rdy), .duc_data_12(q12),
		.duc_data_34(q34), .sync_busy(busy), .fifo_overrun(ovr)
	);
	dsda_conv_model m_u (
		.clock, .rst_b, .sync_in(ddc_sy[0]), .stall, .div_clk,
		.data_12(d12), .data_34(d34), .ready(rdy)
	);
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task conclude;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	// runs well under 6000 clocks; the ceiling only catches a hang
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			conclude();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task step;
		@(posedge clock);
		#1;
	endtask : step
	task sync_run(input int c, input logic [7:0] d);
		int kd;
		ch_cfg[c].delay = d;
		sync_req[c] = 1'b1;
		step();
		sync_req[c] = 1'b0;
		chk(busy[c], 1'b1);
		kd = 0;
		for (k = 1; k < 300 && duc_sy[c] !== 1'b1; k++) begin
			if (ddc_sy[c] === 1'b1) kd = k;
			step();
		end
		chk(kd, 1);
		chk(k, (d == 8'h00) ? 2 : d + 2);
		chk(busy[c], 1'b0);
		repeat (3) step();
	endtask : sync_run
	initial begin
		rst_b = 1'b0;
		stall = 1'b0;
		sync_req = 4'h0;
		fine = 4'h0;
		ch_cfg = '0;
		repeat (3) step();
		rst_b = 1'b1;
		for (int c = 0; c < 4; c++)
			for (int i = 0; i < 4; i++) sync_run(c, dl[i]);
		foreach (fl[i]) begin
			fine = fl[i];
			repeat (20) step();
			x = d34[0];
			repeat (fl[i] + 2) step();
			chk(q34[0], x);
			chk(q34[1], x);
		end
		for (int p = 0; p < 2; p++) begin
			ch_cfg[0].neg_pol = p[0];
			repeat (12) step();
			for (k = 0; k < 9 && vld[0] !== 1'b0; k++) step();
			for (k = 0; k < 9 && vld[0] !== 1'b1; k++) step();
			ph[p] = cyc % 4;
			chk({16'h0000, q12[0].q_smp}, {16'h0000, ~q12[0].i_smp});
			chk({16'h0000, q12[1].q_smp}, {16'h0000, ~q12[1].i_smp});
		end
		chk((ph[1] - ph[0] + 4) % 4, 2);
		chk(ovr, 2'h0);
		stall = 1'b1;
		repeat (100) step();
		chk({ovr, vld}, 4'hf);
		stall = 1'b0;
		x = q12[0];
		n = 0;
		// only the stored run is contiguous; later words follow a gap
		for (k = 0; k < 60 && n < 15; k++) begin
			step();
			if (vld[0] === 1'b1 && q12[0] !== x) begin
				chk(q12[0].i_smp, x.i_smp + 16'h0001);
				x = q12[0];
				n++;
			end
		end
		repeat (40) step();
		chk({ovr[0], n[3:0]}, 5'h1f);
		conclude();
	end
endmodule : dsda_top_tb
